// >>> core/lcdsc_consts.svh
`ifndef LCDSC_CONSTS_SVH
`define LCDSC_CONSTS_SVH

// ==========================================================
// Pin positions inside the synchroniser vector
`define LCDSC_PIN_CS       2
`define LCDSC_PIN_WR       1
`define LCDSC_PIN_RD       0
`define LCDSC_PIN_RST      3'h7

// ==========================================================
// Operation identifiers and field lengths
`define LCDSC_ID_READ      3'h6
`define LCDSC_ID_WRITE     3'h5
`define LCDSC_ID_CMD       3'h4
`define LCDSC_ID_LAST      4'h2
`define LCDSC_ADDR_LAST    4'h5
`define LCDSC_NIB_LAST     4'h3
`define LCDSC_CMD_LAST     4'h8

// ==========================================================
// Command codes (don't-care bits as ?)
`define LCDSC_CMD_OSC_STOP   8'b0000_0000
`define LCDSC_CMD_OSC_START  8'b0000_0001
`define LCDSC_CMD_BIAS_OFF   8'b0000_0010
`define LCDSC_CMD_BIAS_ON    8'b0000_0011
`define LCDSC_CMD_TB_OFF     8'b0000_0100
`define LCDSC_CMD_WDT_OFF    8'b0000_0101
`define LCDSC_CMD_TB_ON      8'b0000_0110
`define LCDSC_CMD_WDT_ON     8'b0000_0111
`define LCDSC_CMD_TONE_OFF   8'b0000_1000
`define LCDSC_CMD_TONE_ON    8'b0000_1001
`define LCDSC_CMD_TB_CLR     8'b0000_11??
`define LCDSC_CMD_WDT_CLR    8'b0000_111?
`define LCDSC_CMD_SRC_XTAL   8'b0001_01??
`define LCDSC_CMD_SRC_RC     8'b0001_10??
`define LCDSC_CMD_SRC_EXT    8'b0001_11??
`define LCDSC_CMD_PANEL      8'b0010_????
`define LCDSC_CMD_PITCH_HI   8'b010?_????
`define LCDSC_CMD_PITCH_LO   8'b011?_????
`define LCDSC_CMD_ALARM_OFF  8'b100?_0???
`define LCDSC_CMD_ALARM_ON   8'b100?_1???
`define LCDSC_CMD_RATE       8'b101?_????
`define LCDSC_CMD_TEST       8'b1110_0000
`define LCDSC_CMD_NORMAL     8'b1110_0011
`define LCDSC_COM_ILLEGAL    2'h3

// ==========================================================
// Reset values and counter limits; tone counts are in 32 kHz base ticks
`define LCDSC_RATE_RST       3'h7
`define LCDSC_COM_RST        2'h0
`define LCDSC_PRE_LAST       3'h7
`define LCDSC_TONE_HI_LAST   3'h3
`define LCDSC_TONE_LO_LAST   3'h7
`define LCDSC_TB_TOP         4'hE
`define LCDSC_WDT_LAST       2'h3

`endif

// >>> core/lcdsc_pkg.sv
package lcdsc_pkg;

  typedef enum logic [2:0] {
    ST_ID   = 3'h0,
    ST_ADDR = 3'h1,
    ST_DATA = 3'h3,
    ST_CMD  = 3'h2,
    ST_HALT = 3'h6
  } lcdsc_state_e;

  typedef enum logic [1:0] {
    OP_NONE  = 2'h0,
    OP_READ  = 2'h1,
    OP_WRITE = 2'h2,
    OP_CMD   = 2'h3
  } lcdsc_op_e;

  typedef enum logic [1:0] {
    SRC_XTAL = 2'h1,
    SRC_RC   = 2'h2,
    SRC_EXT  = 2'h3
  } lcdsc_src_e;

  typedef struct packed {
    logic       osc_run;
    logic       bias_on;
    lcdsc_src_e src;
    logic       bias_third;
    logic [1:0] com_sel;
    logic       tone_on;
    logic       tone_high;
    logic       tb_en;
    logic       watchdog_flag_on_cmd;
    logic       wdt_sel;
    logic       irq_en;
    logic [2:0] rate;
    logic       test_mode;
  } lcdsc_cfg_s;

endpackage : lcdsc_pkg

// >>> core/lcdsc_ram.sv
`timescale 1ns/100ps
`default_nettype none

module lcdsc_ram (
  // Clock
  input  wire logic       sys_clk,
  // Write port
  input  wire logic       we,
  input  wire logic [4:0] waddr,
  input  wire logic [3:0] wdata,
  // Read port
  input  wire logic [4:0] raddr,
  output logic      [3:0] rdata_q
);

  logic [3:0] mem [32];

  always_ff @(posedge sys_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Read of a location written the same cycle returns the old nibble
  always_ff @(posedge sys_clk) begin
    rdata_q <= mem[raddr];
  end

endmodule : lcdsc_ram

`default_nettype wire

// >>> core/lcdsc_decoder.sv
// What this block does
// [R1] Each transfer opens with ID 110 read, 101 write, 100 command.
// [R2] With chip select held low, later commands need no repeated ID.
// [R3] Chip select high aborts the transfer and clears the current mode.
// [R4] Host pulses chip select high before any ID or mode change.
// [R5] Every serial bit is sampled on the write strobe rising edge.
// [R6] Read bits are shifted out on the read strobe falling edge.
// [R7] Host captures read bits between read strobe rise and next fall.
// [R8] Six address bits MSB first, then four data bits LSB first.
// [R9] Write ID also allows read-modify-write: read nibble, then store new one.
// [R10] Code 00 stops oscillator and bias (default); code 01 starts oscillator.
// [R11] Code 02 turns bias off and blanks display; 03 turns bias on.
// [R12] Code 04 disables time base output; 06 enables it toward alarm pin.
// [R13] Code 05 disables watchdog flag; 07 enables watchdog toward alarm pin.
// [R14] Code 08 turns buzzer off (default); 09 turns it on.
// [R15] Codes 0000_11xx clear time base; 0000_111x also clear watchdog.
// [R16] Clock source follows last select: crystal, internal (default), external.
// [R17] Panel code 0010_abXc: c selects bias, ab selects 2/3/4 commons.
// [R18] Codes 010x select 4 kHz tone, 011x select 2 kHz tone.
// [R19] Codes 100x_0 disable alarm output (default); 100x_1 enable it.
// [R20] Codes 101x_xnnn set rate 2^n Hz, watchdog four periods; default 7.
// [R21] Code E0 enters test state; E3 restores normal (default).
// [R22] Host should send full configuration after power-up.
// [R23] After watchdog time-out alarm stays low until watchdog clear or alarm disable (100x_0); code 05 does not release it.
// [R24] Buzzer outputs low while system disabled or tone off.
// [R25] External 256 kHz source divided by eight for the 32 kHz base.
// [R26] Command word is nine bits: eight code bits MSB first, one ignored.
// [R27] Address increments after each nibble of a continued data transfer.
// [R28] Don't-care bits ignored; unlisted codes leave configuration unchanged.
`include "lcdsc_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module lcdsc_decoder
  import lcdsc_pkg::*;
(
  // Clock and reset
  input  wire logic  sys_clk,
  input  wire logic  srst,
  // Host serial pins
  input  wire logic  cs_n,
  input  wire logic  wr_n,
  input  wire logic  rd_n,
  input  wire logic  data_in,
  output logic       data_out_q,
  output logic       data_oe_q,
  // Base ticks from the oscillators
  input  wire logic  osc_tick,
  input  wire logic  ext_tick,
  // Configuration and panel status
  output lcdsc_cfg_s cfg_q,
  output logic       display_on_q,
  output logic       wdt_flag_q,
  // Alarm pin, open drain
  output logic       irq_out_q,
  output logic       irq_oe_q,
  // Buzzer pair
  output logic       buzzer_drive_q,
  output logic       buzzer_drive_n_q
);

  // ==========================================================
  // Pin synchronisers
  logic [2:0]   pin_s1_q;
  logic [2:0]   pin_s2_q;
  logic [2:0]   pin_s3_q;
  logic         dat_s1_q;
  logic         dat_s2_q;
  logic         cs_hi;
  logic         wr_rise;
  logic         rd_fall;
  logic         din;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pin_s1_q <= `LCDSC_PIN_RST;
      pin_s2_q <= `LCDSC_PIN_RST;
      pin_s3_q <= `LCDSC_PIN_RST;
      dat_s1_q <= 1'b1;
      dat_s2_q <= 1'b1;
    end else begin
      pin_s1_q <= {cs_n, wr_n, rd_n};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      dat_s1_q <= data_in;
      dat_s2_q <= dat_s1_q;
    end
  end

  assign cs_hi   = pin_s2_q[`LCDSC_PIN_CS];
  assign wr_rise = pin_s2_q[`LCDSC_PIN_WR] & ~pin_s3_q[`LCDSC_PIN_WR]; // R5
  assign rd_fall = ~pin_s2_q[`LCDSC_PIN_RD] & pin_s3_q[`LCDSC_PIN_RD]; // R6
  assign din     = dat_s2_q;

  // ==========================================================
  // Serial decoder
  lcdsc_state_e state_q;
  lcdsc_op_e    op_q;
  logic [3:0]   bit_cnt_q;
  logic [7:0]   shift_q;
  logic [5:0]   addr_q;
  logic [3:0]   wnib_q;
  logic         cmd_go_q;
  logic [7:0]   cmd_code_q;
  logic         ram_we_q;
  logic [4:0]   ram_waddr_q;
  logic [3:0]   ram_wdata_q;
  logic [3:0]   ram_rdata;
  logic [1:0]   rbit_q;
  logic [2:0]   id_bits;
  logic         rd_bit;

  assign id_bits = {shift_q[1:0], din};
  assign rd_bit  = ram_rdata[rbit_q];

  always_ff @(posedge sys_clk) begin
    cmd_go_q <= 1'b0;
    ram_we_q <= 1'b0;
    if (srst || cs_hi) begin // R3
      state_q   <= ST_ID;
      op_q      <= OP_NONE;
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
    end else if (wr_rise) begin // R5
      bit_cnt_q <= bit_cnt_q + 4'h1;
      unique case (state_q)
        ST_ID: begin
          shift_q <= {shift_q[6:0], din};
          if (bit_cnt_q == `LCDSC_ID_LAST) begin // R1
            bit_cnt_q <= 4'h0;
            if (id_bits == `LCDSC_ID_READ) begin
              op_q    <= OP_READ;
              state_q <= ST_ADDR;
            end else if (id_bits == `LCDSC_ID_WRITE) begin // R9
              op_q    <= OP_WRITE;
              state_q <= ST_ADDR;
            end else if (id_bits == `LCDSC_ID_CMD) begin
              op_q    <= OP_CMD;
              state_q <= ST_CMD;
            end else begin
              state_q <= ST_HALT;
            end
          end
        end
        ST_ADDR: begin
          addr_q <= {addr_q[4:0], din}; // R8
          if (bit_cnt_q == `LCDSC_ADDR_LAST) begin
            bit_cnt_q <= 4'h0;
            state_q   <= ST_DATA;
          end
        end
        ST_DATA: begin
          // Bit 0 arrives first, so new bits enter at the top
          wnib_q <= {din, wnib_q[3:1]}; // R8
          if (bit_cnt_q == `LCDSC_NIB_LAST) begin
            bit_cnt_q <= 4'h0;
            if (op_q == OP_WRITE) begin
              ram_we_q    <= 1'b1;
              ram_waddr_q <= addr_q[4:0];
              ram_wdata_q <= {din, wnib_q[3:1]};
              addr_q      <= addr_q + 6'h1; // R27
            end
          end
        end
        ST_CMD: begin
          shift_q <= {shift_q[6:0], din}; // R26
          if (bit_cnt_q == `LCDSC_CMD_LAST) begin
            // Ninth bit ignored; stay here so the next word needs no ID
            bit_cnt_q  <= 4'h0; // R2
            cmd_go_q   <= 1'b1;
            cmd_code_q <= shift_q;
          end
        end
        ST_HALT: begin
          bit_cnt_q <= 4'h0;
        end
        default: begin
          state_q <= ST_HALT;
        end
      endcase
    end else if (rd_fall && state_q == ST_DATA && op_q == OP_READ
                 && rbit_q == 2'h3) begin
      addr_q <= addr_q + 6'h1; // R27
    end
  end

  // ==========================================================
  // Read-out on the shared data line
  always_ff @(posedge sys_clk) begin
    if (srst || cs_hi) begin
      data_out_q <= 1'b0;
      data_oe_q  <= 1'b0;
      rbit_q     <= 2'h0;
    end else if (rd_fall && state_q == ST_DATA && op_q != OP_CMD) begin
      data_out_q <= rd_bit; // R6
      data_oe_q  <= 1'b1;
      rbit_q     <= rbit_q + 2'h1;
    end else if (wr_rise) begin
      // Host takes the line back for the modify half of R-M-W
      data_oe_q <= 1'b0; // R9
    end
  end

  lcdsc_ram u_ram (
    .sys_clk (sys_clk),
    .we      (ram_we_q),
    .waddr   (ram_waddr_q),
    .wdata   (ram_wdata_q),
    .raddr   (addr_q[4:0]),
    .rdata_q (ram_rdata)
  );

  // ==========================================================
  // Command execution
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cfg_q.osc_run    <= 1'b0;
      cfg_q.bias_on    <= 1'b0;
      cfg_q.src        <= SRC_RC;
      cfg_q.bias_third <= 1'b0;
      cfg_q.com_sel    <= `LCDSC_COM_RST;
      cfg_q.tone_on    <= 1'b0;
      cfg_q.tone_high  <= 1'b0;
      cfg_q.tb_en      <= 1'b0;
      cfg_q.watchdog_flag_on_cmd     <= 1'b0;
      cfg_q.wdt_sel    <= 1'b0;
      cfg_q.irq_en     <= 1'b0;
      cfg_q.rate       <= `LCDSC_RATE_RST;
      cfg_q.test_mode  <= 1'b0;
    end else if (cmd_go_q) begin
      casez (cmd_code_q) // R28
        `LCDSC_CMD_OSC_STOP: begin
          cfg_q.osc_run <= 1'b0; // R10
          cfg_q.bias_on <= 1'b0;
        end
        `LCDSC_CMD_OSC_START: cfg_q.osc_run <= 1'b1; // R10
        `LCDSC_CMD_BIAS_OFF:  cfg_q.bias_on <= 1'b0; // R11
        `LCDSC_CMD_BIAS_ON:   cfg_q.bias_on <= 1'b1; // R11
        `LCDSC_CMD_TB_OFF:    cfg_q.tb_en   <= 1'b0; // R12
        `LCDSC_CMD_WDT_OFF:   cfg_q.watchdog_flag_on_cmd  <= 1'b0; // R13
        `LCDSC_CMD_TB_ON: begin
          cfg_q.tb_en   <= 1'b1; // R12
          cfg_q.wdt_sel <= 1'b0;
        end
        `LCDSC_CMD_WDT_ON: begin
          cfg_q.watchdog_flag_on_cmd  <= 1'b1; // R13
          cfg_q.wdt_sel <= 1'b1;
        end
        `LCDSC_CMD_TONE_OFF:  cfg_q.tone_on <= 1'b0; // R14
        `LCDSC_CMD_TONE_ON:   cfg_q.tone_on <= 1'b1; // R14
        `LCDSC_CMD_SRC_XTAL:  cfg_q.src     <= SRC_XTAL; // R16
        `LCDSC_CMD_SRC_RC:    cfg_q.src     <= SRC_RC; // R16
        `LCDSC_CMD_SRC_EXT:   cfg_q.src     <= SRC_EXT; // R16
        `LCDSC_CMD_PANEL: begin
          // Common count 11 is not a panel setting and is ignored
          if (cmd_code_q[3:2] != `LCDSC_COM_ILLEGAL) begin // R17
            cfg_q.com_sel    <= cmd_code_q[3:2];
            cfg_q.bias_third <= cmd_code_q[0];
          end
        end
        `LCDSC_CMD_PITCH_HI:  cfg_q.tone_high <= 1'b1; // R18
        `LCDSC_CMD_PITCH_LO:  cfg_q.tone_high <= 1'b0; // R18
        `LCDSC_CMD_ALARM_OFF: cfg_q.irq_en    <= 1'b0; // R19
        `LCDSC_CMD_ALARM_ON:  cfg_q.irq_en    <= 1'b1; // R19
        `LCDSC_CMD_RATE:      cfg_q.rate      <= cmd_code_q[2:0]; // R20
        `LCDSC_CMD_TEST:      cfg_q.test_mode <= 1'b1; // R21
        `LCDSC_CMD_NORMAL:    cfg_q.test_mode <= 1'b0; // R21
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // Time base, watchdog and alarm pin
  logic         active;
  logic         base_tick;
  logic         clr_tb;
  logic         watchdog_clear_cmd;
  logic         alarm_off;
  logic [2:0]   pre_q;
  logic [14:0]  tb_cnt_q;
  logic         tb_lvl_q;
  logic         tb_lvl;
  logic [3:0]   tb_idx;
  logic         period_evt;
  logic [1:0]   wdt_cnt_q;
  logic         wdt_set;

  // Stopping the oscillator has no effect on an external source
  assign active     = cfg_q.osc_run | (cfg_q.src == SRC_EXT);
  assign base_tick  = (cfg_q.src == SRC_EXT) ? (ext_tick && pre_q == `LCDSC_PRE_LAST)
                                              : osc_tick; // R25
  assign clr_tb     = cmd_go_q && (cmd_code_q ==? `LCDSC_CMD_TB_CLR); // R15
  assign watchdog_clear_cmd    = cmd_go_q && (cmd_code_q ==? `LCDSC_CMD_WDT_CLR); // R15
  assign alarm_off  = cmd_go_q && (cmd_code_q ==? `LCDSC_CMD_ALARM_OFF);
  assign tb_idx     = `LCDSC_TB_TOP - {1'b0, cfg_q.rate}; // R20
  assign tb_lvl     = tb_cnt_q[tb_idx];
  assign period_evt = tb_lvl_q & ~tb_lvl;
  assign wdt_set    = period_evt && cfg_q.watchdog_flag_on_cmd && wdt_cnt_q == `LCDSC_WDT_LAST;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pre_q <= 3'h0;
    end else if (cfg_q.src == SRC_EXT && ext_tick) begin
      pre_q <= pre_q + 3'h1; // R25
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tb_cnt_q <= 15'h0000;
      tb_lvl_q <= 1'b0;
    end else begin
      // A clear restarts the count; it must not look like a falling rate edge
      tb_lvl_q <= tb_lvl & ~clr_tb;
      if (clr_tb) begin
        tb_cnt_q <= 15'h0000; // R15
      end else if (active && base_tick) begin
        tb_cnt_q <= tb_cnt_q + 15'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wdt_cnt_q  <= 2'h0;
      wdt_flag_q <= 1'b0;
    end else begin
      if (watchdog_clear_cmd) begin
        wdt_cnt_q <= 2'h0; // R15
      end else if (period_evt && cfg_q.watchdog_flag_on_cmd) begin
        wdt_cnt_q <= wdt_cnt_q + 2'h1; // R20
      end
      // A time-out in the clearing cycle still wins
      wdt_flag_q <= wdt_set | (wdt_flag_q & ~(watchdog_clear_cmd | alarm_off)); // R23
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irq_out_q <= 1'b0;
      irq_oe_q  <= 1'b0;
    end else begin
      irq_out_q <= 1'b0;
      irq_oe_q  <= cfg_q.irq_en && (cfg_q.wdt_sel ? wdt_flag_q
                                                  : (cfg_q.tb_en && active && ~tb_lvl)); // R23
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      display_on_q <= 1'b0;
    end else begin
      display_on_q <= cfg_q.bias_on && active; // R11
    end
  end

  // ==========================================================
  // Buzzer pair
  logic [2:0] tone_cnt_q;

  always_ff @(posedge sys_clk) begin
    if (srst || !(cfg_q.tone_on && active)) begin
      tone_cnt_q       <= 3'h0;
      buzzer_drive_q   <= 1'b0; // R24
      buzzer_drive_n_q <= 1'b0;
    end else if (base_tick) begin
      if (tone_cnt_q == (cfg_q.tone_high ? `LCDSC_TONE_HI_LAST : `LCDSC_TONE_LO_LAST)) begin
        tone_cnt_q       <= 3'h0; // R18
        buzzer_drive_q   <= ~buzzer_drive_q; // R14
        buzzer_drive_n_q <= buzzer_drive_q;
      end else begin
        tone_cnt_q <= tone_cnt_q + 3'h1;
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  a_cs_abort: assert property (cs_hi |=> state_q == ST_ID && bit_cnt_q == 4'h0) // R3
    else $error("chip select high did not reset the decoder");
  a_id_command: assert property ((wr_rise && !cs_hi && state_q == ST_ID // R1
      && bit_cnt_q == `LCDSC_ID_LAST && id_bits == `LCDSC_ID_CMD)
      |=> state_q == ST_CMD && op_q == OP_CMD)
    else $error("command ID not decoded");
  a_cmd_chain: assert property ((wr_rise && !cs_hi && state_q == ST_CMD // R2
      && bit_cnt_q == `LCDSC_CMD_LAST)
      |=> cmd_go_q && state_q == ST_CMD && bit_cnt_q == 4'h0)
    else $error("command word not executed or chain lost");
  a_addr_sample: assert property ((wr_rise && !cs_hi && state_q == ST_ADDR) // R5
      |=> addr_q[0] == $past(din))
    else $error("address bit not sampled on write edge");
  a_read_shift: assert property ((rd_fall && !cs_hi && state_q == ST_DATA // R6
      && op_q != OP_CMD) |=> data_oe_q && data_out_q == $past(rd_bit))
    else $error("read bit not shifted out");
  a_nibble_incr: assert property ((wr_rise && !cs_hi && state_q == ST_DATA // R27
      && op_q == OP_WRITE && bit_cnt_q == `LCDSC_NIB_LAST)
      |=> ram_we_q && addr_q == $past(addr_q) + 6'h1)
    else $error("nibble write or address increment missing");
  a_osc_stop: assert property ((cmd_go_q && cmd_code_q == `LCDSC_CMD_OSC_STOP) // R10
      |=> !cfg_q.osc_run && !cfg_q.bias_on)
    else $error("stop command left oscillator or bias running");
  a_rate_set: assert property ((cmd_go_q && cmd_code_q ==? `LCDSC_CMD_RATE) // R20
      |=> cfg_q.rate == cmd_code_q[2:0])
    else $error("rate not taken from command");
  a_tb_clear: assert property (clr_tb |=> tb_cnt_q == 15'h0000) // R15
    else $error("time base not cleared");
  a_buzz_quiet: assert property (!cfg_q.tone_on |=> !buzzer_drive_q && !buzzer_drive_n_q) // R24
    else $error("buzzer driven while tone off");
  a_wdt_hold: assert property ((wdt_flag_q && cfg_q.irq_en && cfg_q.wdt_sel) |=> irq_oe_q) // R23
    else $error("alarm released during watchdog time-out");

  c_command: cover property (cmd_go_q);
  c_ram_write: cover property (ram_we_q);
  c_ram_read: cover property (rd_fall && state_q == ST_DATA && op_q == OP_READ);
  c_wdt_timeout: cover property (wdt_set);

endmodule : lcdsc_decoder

`default_nettype wire

// >>> verification/lcdsc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Host side of the three-wire link
module lcdsc_host_model (
  // Clock
  input  wire logic       sys_clk,
  // Serial pins
  output logic            cs_n,
  output logic            wr_n,
  output logic            rd_n,
  output logic            data_in,
  input  wire logic       data_out_q,
  input  wire logic       data_oe_q,
  // Captured nibble
  output logic            rd_stb,
  output logic      [3:0] rd_nib
);
  logic hoe;
  logic hbit;
  logic last_q;
  // Host wins a clash; a released line toggles so no stale value can pass
  assign data_in = hoe ? hbit : (data_oe_q ? data_out_q : ~last_q);
  always @(posedge sys_clk) last_q <= data_in;
  initial begin
    cs_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    hoe = 1'b1;
    hbit = 1'b1;
    rd_stb = 1'b0;
    rd_nib = 4'h0;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc
  task automatic cs(input logic v);
    cyc(1);
    cs_n = v;
    cyc(4);
  endtask : cs
  task automatic wbit(input logic b);
    wr_n = 1'b0;
    hoe = 1'b1;
    hbit = b;
    cyc(4);
    wr_n = 1'b1;
    cyc(4);
  endtask : wbit
  task automatic wbits(input logic [8:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) wbit(v[i]);
  endtask : wbits
  task automatic wnib(input logic [3:0] v);
    for (int i = 0; i < 4; i++) wbit(v[i]);
  endtask : wnib
  task automatic rnib();
    for (int i = 0; i < 4; i++) begin
      hoe = 1'b0;
      rd_n = 1'b0;
      cyc(4);
      rd_n = 1'b1;
      cyc(1);
      rd_nib[i] = data_in;
      cyc(3);
    end
    rd_stb = 1'b1;
    cyc(1);
    rd_stb = 1'b0;
  endtask : rnib
endmodule : lcdsc_host_model
`default_nettype wire

// >>> verification/tb_lcdsc_decoder.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Bench for the serial command decoder
module tb_lcdsc_decoder import lcdsc_pkg::*;;
  logic        sys_clk  = 1'b0;
  logic        srst     = 1'b1;
  logic        osc_tick = 1'b1;
  logic        ext_tick = 1'b0;
  logic        obs_stb  = 1'b0;
  logic        cs_n;
  logic        wr_n;
  logic        rd_n;
  logic        data_in;
  logic        data_out_q;
  logic        data_oe_q;
  logic        rd_stb;
  logic        display_on_q;
  logic        wdt_flag_q;
  logic        irq_out_q;
  logic        irq_oe_q;
  logic        bz_q;
  logic        bzn_q;
  logic [3:0]  rd_nib;
  logic [3:0]  mem [32];
  logic [16:0] obs_val, got, e;
  logic [16:0] exp_q [$];
  lcdsc_cfg_s  cfg_q;
  lcdsc_cfg_s  exp;
  int          mismatches = 0, tests_run = 0, seed = 55, n;
  logic [7:0]  codes [29] = '{8'h01, 8'h03, 8'h02, 8'h06, 8'h04, 8'h07, 8'h05, 8'h09,
    8'h08, 8'h0C, 8'h0E, 8'h14, 8'h1C, 8'h18, 8'h21, 8'h26, 8'h2F, 8'h2B, 8'h40, 8'h60,
    8'h88, 8'h80, 8'hA0, 8'hA7, 8'hE0, 8'hE3, 8'h0A, 8'h00, 8'hF0};
  logic [7:0]  wd [5] = '{8'h01, 8'hA7, 8'h07, 8'h88, 8'h0E};

  always #10 sys_clk = ~sys_clk;
  always @(negedge sys_clk) ext_tick <= ~ext_tick;

  lcdsc_decoder dut_u (.sys_clk(sys_clk), .srst(srst), .cs_n(cs_n), .wr_n(wr_n),
    .rd_n(rd_n), .data_in(data_in), .data_out_q(data_out_q), .data_oe_q(data_oe_q),
    .osc_tick(osc_tick), .ext_tick(ext_tick), .cfg_q(cfg_q), .display_on_q(display_on_q),
    .wdt_flag_q(wdt_flag_q), .irq_out_q(irq_out_q), .irq_oe_q(irq_oe_q),
    .buzzer_drive_q(bz_q), .buzzer_drive_n_q(bzn_q));
  lcdsc_host_model host_u (.sys_clk(sys_clk), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
    .data_in(data_in), .data_out_q(data_out_q), .data_oe_q(data_oe_q), .rd_stb(rd_stb),
    .rd_nib(rd_nib));

  // ==========================================
  // Result watcher
  always @(posedge sys_clk) begin
    if (rd_stb || obs_stb) begin
      got = rd_stb ? {13'h0, rd_nib} : obs_val;
      tests_run++;
      e = (exp_q.size() != 0) ? exp_q.pop_front() : ~got;
      if (got !== e) begin
        mismatches++;
        $display("Error %0t: got %h expected %h", $time, got, e);
      end
    end
  end

  // ==========================================
  // Reference model and drivers
  function automatic lcdsc_cfg_s apply(lcdsc_cfg_s c, logic [7:0] k);
    casez (k)
      8'h00: begin c.osc_run = 1'b0; c.bias_on = 1'b0; end
      8'h01: c.osc_run = 1'b1;
      8'h02: c.bias_on = 1'b0;
      8'h03: c.bias_on = 1'b1;
      8'h04: c.tb_en = 1'b0;
      8'h05: c.watchdog_flag_on_cmd = 1'b0;
      8'h06: begin c.tb_en = 1'b1; c.wdt_sel = 1'b0; end
      8'h07: begin c.watchdog_flag_on_cmd = 1'b1; c.wdt_sel = 1'b1; end
      8'h08: c.tone_on = 1'b0;
      8'h09: c.tone_on = 1'b1;
      8'b0001_01??: c.src = SRC_XTAL;
      8'b0001_10??: c.src = SRC_RC;
      8'b0001_11??: c.src = SRC_EXT;
      8'b0010_????: if (k[3:2] != 2'h3) begin c.com_sel = k[3:2]; c.bias_third = k[0]; end
      8'b010?_????: c.tone_high = 1'b1;
      8'b011?_????: c.tone_high = 1'b0;
      8'b100?_????: c.irq_en = k[3];
      8'b101?_????: c.rate = k[2:0];
      8'hE0: c.test_mode = 1'b1;
      8'hE3: c.test_mode = 1'b0;
      default: ;
    endcase
    return c;
  endfunction : apply

  task automatic note(input logic [16:0] v);
    exp_q.push_back(v);
  endtask : note
  task automatic snap(input logic [16:0] v);
    obs_val = v;
    obs_stb = 1'b1;
    @(negedge sys_clk);
    obs_stb = 1'b0;
  endtask : snap
  task automatic conclude();
    if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  task automatic cmd(input logic [7:0] k);
    logic x;
    x = 1'($random(seed));
    host_u.wbits({k, x}, 9);
    host_u.cyc(4);
    exp = apply(exp, k);
    note(exp);
    snap(cfg_q);
  endtask : cmd
  task automatic wram(input logic [5:0] a, input int cnt);
    logic [3:0] v;
    host_u.cs(1'b0);
    host_u.wbits(9'h5, 3);
    host_u.wbits({3'h0, a}, 6);
    for (int i = 0; i < cnt; i++) begin
      v = 4'($random(seed));
      host_u.wnib(v);
      mem[5'(a + 6'(i))] = v;
    end
    host_u.cs(1'b1);
  endtask : wram
  task automatic rram(input logic [5:0] a, input int cnt);
    host_u.cs(1'b0);
    host_u.wbits(9'h6, 3);
    host_u.wbits({3'h0, a}, 6);
    for (int i = 0; i < cnt; i++) begin
      note({13'h0, mem[5'(a + 6'(i))]});
      host_u.rnib();
    end
    host_u.cs(1'b1);
  endtask : rram
  // Counts buzzer rises over 60 cycles, starting at a rise when sync is set
  task automatic buzz(input logic sync, output int r);
    int w;
    logic p;
    r = 0;
    w = 0;
    while (sync && w < 100) begin
      p = bz_q;
      @(negedge sys_clk);
      w = (!p && bz_q) ? 200 : w + 1;
    end
    if (sync && w != 200) begin
      mismatches++;
      $display("Error %0t: no buzzer edge seen", $time);
      conclude();
    end
    repeat (60) begin
      p = bz_q;
      @(negedge sys_clk);
      r += (!p && bz_q) ? 1 : 0;
    end
  endtask : buzz

  // ==========================================
  // Main sequence
  initial begin
    repeat (20) @(negedge sys_clk);
    srst = 1'b0;
    exp = '0;
    exp.src = SRC_RC;
    exp.rate = 3'h7;
    host_u.cyc(2);
    note(exp);
    snap(cfg_q);
    note(17'h0);
    snap({10'h0, irq_out_q, data_oe_q, irq_oe_q, bz_q, bzn_q, display_on_q, wdt_flag_q});
    host_u.cs(1'b0);
    host_u.wbits(9'h4, 3);
    foreach (codes[i]) cmd(codes[i]);
    repeat (40) cmd(8'($random(seed)));
    host_u.cs(1'b1);
    // Aborted word, then an unknown identifier: neither may touch the setup
    host_u.cs(1'b0);
    host_u.wbits(9'h4, 3);
    host_u.wbits(9'h14, 5);
    host_u.cs(1'b1);
    note(exp);
    snap(cfg_q);
    host_u.cs(1'b0);
    host_u.wbits(9'h7, 3);
    host_u.wbits({5'h14, ~exp.rate, 1'b0}, 9);
    host_u.cs(1'b1);
    note(exp);
    snap(cfg_q);
    wram(6'h1E, 3);
    wram(6'h25, 1);
    host_u.cs(1'b0);
    host_u.wbits(9'h5, 3);
    host_u.wbits(9'h05, 6);
    host_u.wbits(9'h3, 2);
    host_u.cs(1'b1);
    rram(6'h1E, 3);
    rram(6'h05, 1);
    host_u.cs(1'b0);
    host_u.wbits(9'h5, 3);
    host_u.wbits(9'h1F, 6);
    note({13'h0, mem[31]});
    host_u.rnib();
    mem[31] = 4'hA;
    host_u.wnib(4'hA);
    mem[0] = 4'h5;
    host_u.wnib(4'h5);
    host_u.cs(1'b1);
    rram(6'h3F, 2);
    host_u.cs(1'b0);
    host_u.wbits(9'h4, 3);
    cmd(8'h18);
    cmd(8'h01);
    cmd(8'h09);
    cmd(8'h40);
    buzz(1'b1, n);
    note(17'h7);
    snap(17'(n));
    cmd(8'h60);
    buzz(1'b1, n);
    note(17'h3);
    snap(17'(n));
    cmd(8'h00);
    buzz(1'b0, n);
    note(17'h0);
    snap(17'(n));
    cmd(8'h08);
    foreach (wd[i]) cmd(wd[i]);
    n = 0;
    while (!irq_oe_q && n < 1500) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 1500) begin
      mismatches++;
      $display("Error %0t: watchdog alarm never raised", $time);
      conclude();
    end
    note(17'h1);
    snap(17'(n > 950 && n < 1100));
    n = 0;
    repeat (100) begin
      @(negedge sys_clk);
      n += irq_oe_q ? 0 : 1;
    end
    note(17'h0);
    snap(17'(n));
    cmd(8'h0E);
    host_u.cyc(2);
    note(17'h0);
    snap({16'h0, irq_oe_q});
    host_u.cs(1'b1);
    conclude();
  end
endmodule : tb_lcdsc_decoder
`default_nettype wire
